// ===== rtl/flut9_pkg.sv
/*
 * flut9_pkg: constants for the fan lookup-table step nine register bank.
 * Assumes a 32-bit Avalon-MM slave with word addressing by byte address / 4.
 */
package flut9_pkg;
    // printed register indices; byte address is four times the index
    localparam logic [7:0] IDX_STEP9_TEMP = 8'h60;
    localparam logic [7:0] IDX_STEP9_DUTY = 8'h61;
    localparam logic [7:0] IDX_STEP8_DUTY = 8'h5F;
    localparam logic [7:0] IDX_LUT_CTRL = 8'h4A;
    localparam logic [7:0] IDX_LUT_OFFSET = 8'h4E;
    // own register: mode bits and remote temperature input
    localparam logic [7:0] IDX_MODE = 8'hF0;
    localparam logic [7:0] IDX_STATUS = 8'hF1;
    // field positions
    localparam int LUT_CTRL_UNLOCK_BIT = 5;
    localparam int MODE_TEMP_HIRES_BIT = 0;
    localparam int MODE_DUTY_HIRES_BIT = 1;
    localparam int MODE_PWM_22K5_BIT = 2;
    localparam int TEMP_HALF_BIT = 7;
    localparam int DUTY_EXT_LSB = 6;
    // reset values
    localparam logic [6:0] STEP9_TEMP_MAIN_RST = 7'h7F;
    localparam logic STEP9_TEMP_HALF_RST = 1'h0;
    localparam logic [5:0] STEP9_DUTY_MAIN_RST = 6'h3F;
    localparam logic [1:0] STEP9_DUTY_EXT_RST = 2'h0;
    localparam logic [5:0] STEP8_DUTY_MAIN_RST = 6'h3F;
    localparam logic [7:0] LUT_CTRL_RST = 8'h00;
    localparam logic [7:0] LUT_OFFSET_RST = 8'h00;
    localparam logic [2:0] MODE_RST = 3'h0;
endpackage : flut9_pkg

// ===== rtl/flut9_bank.sv
/*
 * flut9_bank: step nine of the fan-speed lookup table with its register bank.
 * Assumes remote temperature arrives as an 11-bit unsigned value in eighths of a degree,
 * synchronous to sys_clk; the PWM generator downstream consumes fan_duty.
 */
// Chosen here: register access over Avalon-MM.
// Contract
// - low-res temperature mode keeps threshold bit 7 at zero, unused.
// - high-res temperature mode forms an eight-bit threshold, 0 to 127.5 degrees.
// - low-res temperature mode compares eight reading bits, range 0 to 255.
// - temperature above step nine threshold selects step nine duty.
// - thresholds are positive only; sign bit taken as zero.
// - lookup offset register extends thresholds above 127 degrees.
// - table always readable; writes accepted only while unlock bit set.
// - reset loads threshold main bits 0x7F, half bit clear.
// - reset loads duty main bits 0x3F, extended bits zero.
// - low-res duty mode keeps extended duty bits at zero, unused.
// - high-res duty mode joins extended and main bits into duty.
// - extended duty bits take effect only with 22.5kHz selected.
// - low-res mode uses step nine main duty bits for threshold 0x60.
// - low-res mode uses step eight main duty bits for its threshold.
`timescale 1ns/100ps
module flut9_bank
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // avalon-mm slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    // measured remote temperature, eighths of a degree, unsigned
    input wire logic [10:0] remote_temp,
    // step eight threshold exceeded, from the neighbouring step
    input wire logic step8_exceeded,
    // fan duty request to the pwm generator
    output logic [7:0] fan_duty,
    output logic fan_duty_valid,
    output logic step9_exceeded
);
    import flut9_pkg::*;

    logic [6:0] step9_temp_main_bits;
    logic step9_temp_half_bit;
    logic [5:0] step9_duty_main_bits;
    logic [1:0] step9_duty_extended_bits;
    logic [5:0] step8_duty_main_bits;
    logic [7:0] lut_ctrl;
    logic [7:0] lut_offset;
    logic [2:0] mode;
    logic ack;
    logic [7:0] idx;
    logic req;
    logic unlocked;
    logic temp_hires;
    logic duty_hires;
    logic pwm_22k5;
    logic wr_lane0;
    logic [9:0] threshold_half;
    logic [9:0] temp_half;
    logic [7:0] next_duty;

    // decode whether an index is a mapped register
    function automatic logic is_mapped(input logic [7:0] i);
        is_mapped = (i == IDX_STEP9_TEMP) || (i == IDX_STEP9_DUTY) || (i == IDX_STEP8_DUTY)
            || (i == IDX_LUT_CTRL) || (i == IDX_LUT_OFFSET) || (i == IDX_MODE)
            || (i == IDX_STATUS);
    endfunction : is_mapped

    assign idx = avs_address[9:2];
    assign req = avs_read | avs_write;
    assign unlocked = lut_ctrl[LUT_CTRL_UNLOCK_BIT];
    assign temp_hires = mode[MODE_TEMP_HIRES_BIT];
    assign duty_hires = mode[MODE_DUTY_HIRES_BIT];
    assign pwm_22k5 = mode[MODE_PWM_22K5_BIT];
    // a write commits in the cycle where waitrequest is low, the edge the master trusts
    assign wr_lane0 = avs_write & avs_byteenable[0] & ack;

    // one wait cycle per access: waitrequest drops on the second cycle of a request
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            ack <= 1'b0;
        else
            ack <= req & ~ack;
    end
    assign avs_waitrequest = req & ~ack;

    // unmapped addresses answer with slave error, reads return zero
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'h0;
        end
        else if (req & ~ack)
        begin
            avs_response <= is_mapped(idx) ? 2'h0 : 2'h2;
            avs_readdata <= 32'h0000_0000;
            if (avs_read)
            begin
                case (idx)
                    IDX_STEP9_TEMP: avs_readdata[7:0] <= {step9_temp_half_bit,
                        step9_temp_main_bits};
                    IDX_STEP9_DUTY: avs_readdata[7:0] <= {step9_duty_extended_bits,
                        step9_duty_main_bits};
                    IDX_STEP8_DUTY: avs_readdata[7:0] <= {2'h0, step8_duty_main_bits};
                    IDX_LUT_CTRL: avs_readdata[7:0] <= lut_ctrl;
                    IDX_LUT_OFFSET: avs_readdata[7:0] <= lut_offset;
                    IDX_MODE: avs_readdata[7:0] <= {5'h00, mode};
                    IDX_STATUS: avs_readdata[10:0] <= remote_temp;
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // control registers: lock, offset and modes are never write protected
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            lut_ctrl <= LUT_CTRL_RST;
            lut_offset <= LUT_OFFSET_RST;
            mode <= MODE_RST;
        end
        else if (wr_lane0)
        begin
            if (idx == IDX_LUT_CTRL)
                lut_ctrl <= avs_writedata[7:0];
            if (idx == IDX_LUT_OFFSET)
                lut_offset <= avs_writedata[7:0];
            if (idx == IDX_MODE)
                mode <= avs_writedata[2:0];
        end
    end

    // step nine threshold; half bit forced clear in low resolution
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            step9_temp_main_bits <= STEP9_TEMP_MAIN_RST;
            step9_temp_half_bit <= STEP9_TEMP_HALF_RST;
        end
        else
        begin
            if (wr_lane0 && unlocked && idx == IDX_STEP9_TEMP)
            begin
                step9_temp_main_bits <= avs_writedata[6:0];
                step9_temp_half_bit <= avs_writedata[TEMP_HALF_BIT] & temp_hires;
            end
            else if (!temp_hires)
                step9_temp_half_bit <= 1'b0;
        end
    end

    // duty registers; extended bits held clear unless high-res duty mode
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            step9_duty_main_bits <= STEP9_DUTY_MAIN_RST;
            step9_duty_extended_bits <= STEP9_DUTY_EXT_RST;
            step8_duty_main_bits <= STEP8_DUTY_MAIN_RST;
        end
        else
        begin
            if (wr_lane0 && unlocked && idx == IDX_STEP9_DUTY)
            begin
                step9_duty_main_bits <= avs_writedata[5:0];
                step9_duty_extended_bits <= duty_hires ? avs_writedata[7:DUTY_EXT_LSB]
                    : 2'h0;
            end
            else if (!duty_hires)
                step9_duty_extended_bits <= 2'h0;
            if (wr_lane0 && unlocked && idx == IDX_STEP8_DUTY)
                step8_duty_main_bits <= avs_writedata[5:0];
        end
    end

    // compare in half degrees; low-res drops the half bit of both sides
    // threshold and offset are unsigned, so the sign is implicitly zero
    always_comb
    begin
        threshold_half = {2'h0, step9_temp_main_bits, step9_temp_half_bit}
            + {1'h0, lut_offset, 1'h0};
        temp_half = remote_temp[10:2] + 10'h000;
        if (!temp_hires)
            temp_half[0] = 1'b0;
    end

    // duty selection for this step, else the step before it
    always_comb
    begin
        next_duty = 8'h00;
        if (temp_half > threshold_half)
        begin
            if (duty_hires && pwm_22k5)
                next_duty = {step9_duty_extended_bits, step9_duty_main_bits};
            else
                next_duty = {2'h0, step9_duty_main_bits};
        end
        else if (step8_exceeded)
            next_duty = {2'h0, step8_duty_main_bits};
    end

    // registered outputs to the pwm generator
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fan_duty <= 8'h00;
            fan_duty_valid <= 1'b0;
            step9_exceeded <= 1'b0;
        end
        else
        begin
            fan_duty <= next_duty;
            fan_duty_valid <= (temp_half > threshold_half) | step8_exceeded;
            step9_exceeded <= temp_half > threshold_half;
        end
    end

    // assertions: loose bits under the resolution modes
    // half bit is cleared one cycle after low resolution is seen
    half_bit_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !temp_hires |=> (!temp_hires -> !step9_temp_half_bit))
        else $error("half bit set in low resolution");

    // extended duty bits follow the same one-cycle clearing
    ext_bits_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !duty_hires |=> (!duty_hires -> step9_duty_extended_bits == 2'h0))
        else $error("extended duty bits set in low resolution");

    // high resolution keeps the written half bit
    half_bit_high_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (wr_lane0 && unlocked && temp_hires && idx == IDX_STEP9_TEMP)
        |=> step9_temp_half_bit == $past(avs_writedata[TEMP_HALF_BIT]))
        else $error("half bit not stored in high resolution");

    // assertions: write lock and bus timing
    // no register changes while the master still sees a wait state
    write_commit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_lane0 |-> !avs_waitrequest)
        else $error("write committed during wait state");

    // locked duty register ignores writes
    locked_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (wr_lane0 && !unlocked && idx == IDX_STEP9_DUTY)
        |=> $stable(step9_duty_main_bits))
        else $error("duty changed while locked");

    // locked threshold register ignores writes
    locked_temp_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (wr_lane0 && !unlocked && idx == IDX_STEP9_TEMP)
        |=> $stable(step9_temp_main_bits))
        else $error("threshold changed while locked");

    // locked step eight duty ignores writes
    locked_step8_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (wr_lane0 && !unlocked && idx == IDX_STEP8_DUTY)
        |=> $stable(step8_duty_main_bits))
        else $error("step eight duty changed while locked");

    // unlocked duty write lands with the written value
    open_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (wr_lane0 && unlocked && idx == IDX_STEP9_DUTY)
        |=> step9_duty_main_bits == $past(avs_writedata[5:0]))
        else $error("unlocked duty write lost");

    // threshold reads back whatever the lock state
    read_temp_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (avs_read && !ack && idx == IDX_STEP9_TEMP)
        |=> avs_readdata[7:0] == $past({step9_temp_half_bit, step9_temp_main_bits}))
        else $error("threshold readback wrong");

    // read data must not move once the answer is out
    read_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ack |=> $stable(avs_readdata))
        else $error("read data moved after answer");

    // unmapped index answers with slave error
    unmapped_resp_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (req && !ack && !is_mapped(idx)) |=> avs_response == 2'h2)
        else $error("unmapped access not refused");

    // exactly one wait cycle per request
    wait_one_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after one wait cycle");

    // assertions: comparison and duty selection
    // nine-bit compare in high resolution raises the flag
    exceed_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (remote_temp[10:2] > ({2'h0, step9_temp_main_bits, step9_temp_half_bit}
        + {1'h0, lut_offset, 1'h0})) && temp_hires |=> step9_exceeded)
        else $error("threshold exceed not flagged");

    // low resolution compares whole degrees only
    lowres_compare_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!temp_hires && ({1'h0, remote_temp[10:3]}
        <= {2'h0, step9_temp_main_bits} + {1'h0, lut_offset})) |=> !step9_exceeded)
        else $error("low resolution compare used fraction");

    // half a degree above the threshold is enough in high resolution
    half_weight_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (temp_hires && {1'h0, remote_temp[10:2]} == threshold_half + 10'h001)
        |=> step9_exceeded)
        else $error("half degree step not honoured");

    // a nonzero offset lifts the effective threshold
    offset_raise_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (temp_hires && lut_offset != 8'h00 && {1'h0, remote_temp[10:2]}
        == {2'h0, step9_temp_main_bits, step9_temp_half_bit} + 10'h001) |=> !step9_exceeded)
        else $error("offset not applied to threshold");

    // not above the threshold means no flag
    no_exceed_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !(temp_half > threshold_half) |=> !step9_exceeded)
        else $error("exceed flagged below threshold");

    // neither step active drives zero duty, not valid
    idle_duty_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!(temp_half > threshold_half) && !step8_exceeded)
        |=> (fan_duty == 8'h00 && !fan_duty_valid))
        else $error("idle duty not zero");

    // low resolution or slow pwm uses the main duty bits
    step9_duty_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (temp_half > threshold_half && !(duty_hires && pwm_22k5))
        |=> fan_duty == {2'h0, $past(step9_duty_main_bits)})
        else $error("step nine duty not applied");

    // extended bits reach the output in high resolution at 22.5kHz
    hires_duty_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (temp_half > threshold_half && duty_hires && pwm_22k5)
        |=> fan_duty[7:6] == $past(step9_duty_extended_bits))
        else $error("extended duty not applied");

    // main bits stay below the extended ones in high resolution
    hires_main_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (temp_half > threshold_half && duty_hires && pwm_22k5)
        |=> fan_duty[5:0] == $past(step9_duty_main_bits))
        else $error("main duty bits lost in high resolution");

    // without 22.5kHz the top duty bits never show
    ext_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !(duty_hires && pwm_22k5) |=> fan_duty[7:6] == 2'h0)
        else $error("extended duty used without 22.5kHz");

    // below this step the step eight duty is passed on
    step8_duty_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!(temp_half > threshold_half) && step8_exceeded)
        |=> fan_duty == {2'h0, $past(step8_duty_main_bits)})
        else $error("step eight duty not applied");
endmodule : flut9_bank

// ===== verification/flut9_tb.sv
/*
 * tb: self-checking bench for flut9_bank, registers over avalon-mm and the fan duty output.
 * Assumes the one-wait-state slave and the register indices of flut9_pkg.
 */
`timescale 1ns/100ps
module tb;
    import flut9_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [9:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] avs_response;
    logic [10:0] remote_temp = '0;
    logic step8_exceeded = 1'b0;
    logic [7:0] fan_duty;
    logic fan_duty_valid;
    logic step9_exceeded;
    int error_cnt = 0;
    int compares = 0;
    flut9_bank DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .remote_temp(remote_temp), .step8_exceeded(step8_exceeded), .fan_duty(fan_duty),
        .fan_duty_valid(fan_duty_valid), .step9_exceeded(step9_exceeded));
    // 50 MHz system clock
    initial
    begin
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic end_sim;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim
    task automatic cmp_reg(input logic [33:0] got, input logic [33:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t reg got %h exp %h", $time, got, exp);
        end
    endtask : cmp_reg
    task automatic cmp_fan(input logic [9:0] got, input logic [9:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t fan got %h exp %h", $time, got, exp);
        end
    endtask : cmp_fan
    // one bus cycle; a fresh edge first so no signal is assigned twice in a step
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
        output logic [33:0] res);
        logic done;
        done = 1'b0;
        @(posedge sys_clk);
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {24'h000000, wd};
        // the settled level before an edge is what that rising edge samples
        for (int n = 0; n < 20 && !done; n++)
        begin
            @(negedge sys_clk);
            done = (avs_waitrequest === 1'b0);
            @(posedge sys_clk);
        end
        res = {avs_response, avs_readdata};
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (!done)
        begin
            error_cnt++;
            end_sim();
        end
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [33:0] r;
        bus(1'b1, idx, d, r);
    endtask : wr
    task automatic rd_chk(input logic [7:0] idx, input logic [33:0] exp);
        logic [33:0] r;
        bus(1'b0, idx, 8'h00, r);
        cmp_reg(r, exp);
    endtask : rd_chk
    // temperature in eighths; expected {valid, exceeded, duty}
    task automatic fan(input logic [10:0] t, input logic s8, input logic [9:0] exp);
        @(posedge sys_clk);
        remote_temp <= t;
        step8_exceeded <= s8;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        cmp_fan({fan_duty_valid, step9_exceeded, fan_duty}, exp);
    endtask : fan
    task automatic reset_scn;
        rd_chk(IDX_STEP9_TEMP, 34'h00000007F);
        rd_chk(IDX_STEP9_DUTY, 34'h00000003F);
        rd_chk(IDX_STEP8_DUTY, 34'h00000003F);
        rd_chk(8'h10, 34'h200000000);
        wr(IDX_STEP9_TEMP, 8'h28);
        rd_chk(IDX_STEP9_TEMP, 34'h00000007F);
        fan(11'h400, 1'b0, 10'h33F);
        fan(11'h3FC, 1'b0, 10'h000);
    endtask : reset_scn
    task automatic lowres_scn;
        wr(IDX_LUT_CTRL, 8'h20);
        rd_chk(IDX_LUT_CTRL, 34'h000000020);
        wr(IDX_STEP9_TEMP, 8'hA8);
        rd_chk(IDX_STEP9_TEMP, 34'h000000028);
        wr(IDX_STEP9_DUTY, 8'hD5);
        rd_chk(IDX_STEP9_DUTY, 34'h000000015);
        fan(11'h144, 1'b0, 10'h000);
        fan(11'h148, 1'b0, 10'h315);
    endtask : lowres_scn
    task automatic hires_scn;
        wr(IDX_MODE, 8'h07);
        wr(IDX_STEP9_TEMP, 8'hA8);
        rd_chk(IDX_STEP9_TEMP, 34'h0000000A8);
        wr(IDX_STEP9_DUTY, 8'hD5);
        rd_chk(IDX_STEP9_DUTY, 34'h0000000D5);
        fan(11'h145, 1'b0, 10'h000);
        fan(11'h148, 1'b0, 10'h3D5);
        wr(IDX_MODE, 8'h03);
        fan(11'h148, 1'b0, 10'h315);
    endtask : hires_scn
    task automatic step8_scn;
        wr(IDX_STEP8_DUTY, 8'hEA);
        rd_chk(IDX_STEP8_DUTY, 34'h00000002A);
        fan(11'h0A0, 1'b1, 10'h22A);
    endtask : step8_scn
    task automatic offset_scn;
        wr(IDX_LUT_OFFSET, 8'h0A);
        fan(11'h194, 1'b0, 10'h000);
        fan(11'h198, 1'b0, 10'h315);
        wr(IDX_LUT_OFFSET, 8'h00);
        wr(IDX_STEP9_TEMP, 8'hFF);
        fan(11'h320, 1'b0, 10'h000);
        fan(11'h400, 1'b0, 10'h315);
    endtask : offset_scn
    // main sequence
    initial
    begin
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        reset_scn();
        lowres_scn();
        hires_scn();
        step8_scn();
        offset_scn();
        end_sim();
    end
endmodule : tb
